// [design/gmq_map.svh]
// Constants for the pin multiplexer and input qualifier block.
// Assumes one system clock; included by the package and by each module using it.
//
// Behaviour
// - Each pin's function comes from its own 2-bit field in one of three selects
// - A reserved function value connects no peripheral; the pin may still be driven
// - Each pin has an input qualification mode chosen from four options
// - Mode 0,0 is the reset default and only synchronises the input
// - Modes 0,1 and 1,0 synchronise, then hold the input until qualified
// - Sample period comes from the control register, shared by groups of 8 pins
// - Window is 3 or 6 samples; output changes only when all samples agree
// - Mode 1,1 passes the input unsynchronised to the peripheral
// - An unselected peripheral input sits at its own fixed default level
// - One peripheral input may be routed from several candidate pins
`ifndef GMQ_MAP_SVH
`define GMQ_MAP_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define GMQ_NPIN 35
`define GMQ_NGRP 5
`define GMQ_NPI 6
`define GMQ_NONE 3'h7
`define GMQ_WIN3 3'h3
`define GMQ_WIN6 3'h6

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define GMQ_FSEL_A1 6'h00
`define GMQ_FSEL_A2 6'h04
`define GMQ_FSEL_B1 6'h08
`define GMQ_QSEL_A1 6'h0c
`define GMQ_QSEL_A2 6'h10
`define GMQ_QSEL_B1 6'h14
`define GMQ_QCTL_A 6'h18
`define GMQ_QCTL_B 6'h1c
`define GMQ_LVL_A 6'h20
`define GMQ_LVL_B 6'h24

// ----------------------------------------
// Reset values and peripheral input defaults
// ----------------------------------------
`define GMQ_RST32 32'h0000_0000
`define GMQ_PI_DEFAULT 6'h0f

`endif

// [design/gmq_pkg.sv]
// Types and decode helpers for the pin multiplexer block.
// Assumes the constants header sits beside it.
`include "gmq_map.svh"

package gmq_pkg;

	typedef enum logic [1:0] {QM_SYNC, QM_WIN3, QM_WIN6, QM_ASYNC} gmq_qmode_e;

	// Two-bit field of pin p from a packed select vector
	function automatic logic [1:0] gmq_field(input logic [69:0] v, input int p);
		return v[2*p +: 2];
	endfunction

	// Peripheral input fed by pin p under select s; none when not an input
	function automatic logic [2:0] gmq_route(input int p, input logic [1:0] s);
		logic [7:0] key;
		key = {p[5:0], s};
		case (key)
			{6'd10, 2'h2}, {6'd13, 2'h2}, {6'd17, 2'h2}, {6'd21, 2'h3}: return 3'h0;
			{6'd11, 2'h2}, {6'd15, 2'h2}, {6'd19, 2'h2}, {6'd23, 2'h3}: return 3'h1;
			{6'd16, 2'h3}, {6'd28, 2'h3}: return 3'h2;
			{6'd17, 2'h3}, {6'd29, 2'h3}: return 3'h3;
			{6'd6, 2'h2}, {6'd32, 2'h2}: return 3'h4;
			{6'd24, 2'h2}: return 3'h5;
			default: return `GMQ_NONE;
		endcase
	endfunction

endpackage

// [design/gmq_cfg_if.sv]
// Carrier between the register side and the qualifier side.
// Assumes all users run on the same system clock.
`timescale 1ns/100ps

interface gmq_cfg_if;
	logic [69:0] qsel;
	logic [39:0] period;
	logic [4:0] tick;
	logic [34:0] qval;

	modport ctl (output qsel, output period, input tick, input qval);
	modport tck (input period, output tick);
	modport qual (input qsel, input tick, output qval);
endinterface

// [design/gmq_tick.sv]
// Sample tick generator, one counter per group of eight pins.
// Assumes period fields come straight from software registers.
`timescale 1ns/100ps
`include "gmq_map.svh"

module gmq_tick import gmq_pkg::*; (
	input wire logic mclk, // System clock
	input wire logic rst_n, // Async reset, active low
	gmq_cfg_if.tck cfg // Period in, tick out
);

	typedef struct packed {
		logic [4:0][7:0] cnt;
		logic [4:0] tick;
	} gmq_tick_s;

	gmq_tick_s st;
	gmq_tick_s next_st;

	// group sample period
	// Tick every period+1 cycles; zero samples on every cycle
	always_comb begin
		next_st = st;
		for (int g = 0; g < `GMQ_NGRP; g++) begin
			next_st.tick[g] = (st.cnt[g] >= cfg.period[8*g +: 8]);
			next_st.cnt[g] = next_st.tick[g] ? 8'h00 : st.cnt[g] + 8'h01;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign cfg.tick = st.tick;

	default clocking dc @(posedge mclk); endclocking
	default disable iff (!rst_n);

	chk_tick_spacing: assert property (
		$stable(cfg.period[7:0])[*3] ##0 (st.tick[0] && cfg.period[7:0] == 8'h03)
		|-> $past(!st.tick[0]) && $past(!st.tick[0], 2) && $past(!st.tick[0], 3))
	else $error("group tick came faster than its period");

endmodule

// [design/gmq_qual.sv]
// Per-pin synchroniser and sampling-window qualifier.
// Assumes pins are asynchronous to mclk and ticks come from gmq_tick.
`timescale 1ns/100ps
`include "gmq_map.svh"

module gmq_qual import gmq_pkg::*; (
	input wire logic mclk, // System clock
	input wire logic rst_n, // Async reset, active low
	input wire logic [34:0] pin_in, // Raw pad levels
	gmq_cfg_if.qual cfg // Modes and ticks in, levels out
);

	typedef struct packed {
		logic [34:0] s1;
		logic [34:0] s2;
		logic [34:0] s3;
		logic [34:0] sv;
		logic [34:0] raw;
		logic [34:0] q;
		logic [34:0][2:0] cnt;
	} gmq_qual_s;

	gmq_qual_s st;
	gmq_qual_s next_st;
	logic [34:0] out;

	// Three-stage chain; a change counts once stages two and three agree
	always_comb begin
		gmq_qmode_e m;
		logic [2:0] win;
		m = QM_SYNC;
		win = `GMQ_WIN3;
		next_st = st;
		next_st.s1 = pin_in;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		next_st.raw = pin_in;
		for (int p = 0; p < `GMQ_NPIN; p++) begin
			if (st.s2[p] == st.s3[p]) begin
				next_st.sv[p] = st.s3[p];
			end
			m = gmq_qmode_e'(gmq_field(cfg.qsel, p));
			win = (m == QM_WIN6) ? `GMQ_WIN6 : `GMQ_WIN3;
			if (m == QM_WIN3 || m == QM_WIN6) begin
				if (st.sv[p] == st.q[p]) begin
					next_st.cnt[p] = 3'h0;
				end else if (cfg.tick[p >> 3]) begin
					if (st.cnt[p] + 3'h1 == win) begin
						next_st.q[p] = st.sv[p];
						next_st.cnt[p] = 3'h0;
					end else begin
						next_st.cnt[p] = st.cnt[p] + 3'h1;
					end
				end
			end else begin
				next_st.q[p] = st.sv[p];
				next_st.cnt[p] = 3'h0;
			end
			out[p] = (m == QM_ASYNC) ? st.raw[p] : st.q[p];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign cfg.qval = out;

	default clocking dc @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_agree2;
		st.s2[2] == st.s3[2];
	endsequence

	chk_sync_follow: assert property (
		(gmq_field(cfg.qsel, 2) == 2'h0 and s_agree2) ##0 $stable(cfg.qsel[5:4])[*2]
		|-> ##1 cfg.qval[2] == $past(st.s3[2], 2))
	else $error("sync mode output did not follow the agreed sample");

	chk_win3_count: assert property (
		$changed(st.q[0]) && $past(gmq_field(cfg.qsel, 0)) == 2'h1
		|-> $past(st.cnt[0]) == 3'h2 && $past(cfg.tick[0]))
	else $error("3-sample window changed before three samples");

	chk_win6_count: assert property (
		$changed(st.q[1]) && $past(gmq_field(cfg.qsel, 1)) == 2'h2
		|-> $past(st.cnt[1]) == 3'h5 && $past(cfg.tick[0]))
	else $error("6-sample window changed before six samples");

	chk_async_pass: assert property (
		gmq_field(cfg.qsel, 3) == 2'h3 ##1 gmq_field(cfg.qsel, 3) == 2'h3
		|-> cfg.qval[3] == $past(pin_in[3]))
	else $error("async mode did not pass the pin through");

endmodule

// [design/gmq_top.sv]
// Pin function multiplexer with input qualification and Avalon-MM registers.
// Assumes peripherals and the GPIO data block sit on mclk beside it.
//
// Register access over Avalon-MM and the address map were decided locally.
`timescale 1ns/100ps
`include "gmq_map.svh"

module gmq_top import gmq_pkg::*; (
	input wire logic mclk, // System clock, 250 MHz
	input wire logic rst_n, // Async reset, active low
	input wire logic [5:0] avs_address, // Byte address
	input wire logic avs_read, // Read request
	input wire logic avs_write, // Write request
	input wire logic [31:0] avs_writedata, // Write data
	input wire logic [3:0] avs_byteenable, // Byte lanes
	output logic [31:0] avs_readdata, // Read data
	output logic avs_waitrequest, // Stall, low at the answer
	input wire logic [34:0] pin_in, // Pad input levels
	output logic [34:0] pin_out, // Pad output levels
	output logic [34:0] pin_oe_n, // Pad drive enable, low drives
	input wire logic [34:0] gpio_dout, // GPIO output data
	input wire logic [34:0] gpio_dir, // GPIO direction, high is output
	output logic [34:0] gpio_din, // Qualified input levels
	input wire logic [104:0] alt_dout, // Peripheral data, 3 per pin
	input wire logic [104:0] alt_oe, // Peripheral enables, 3 per pin
	output logic [5:0] periph_in // Routed peripheral inputs
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [31:0] fsel_a1;
		logic [31:0] fsel_a2;
		logic [5:0] fsel_b1;
		logic [31:0] qsel_a1;
		logic [31:0] qsel_a2;
		logic [5:0] qsel_b1;
		logic [31:0] qctl_a;
		logic [7:0] qctl_b;
		logic wait_r;
		logic [31:0] rdata;
		logic [34:0] pout;
		logic [34:0] poen;
		logic [34:0] gdin;
		logic [5:0] pin_r;
	} gmq_top_s;

	gmq_top_s st;
	gmq_top_s next_st;
	logic [69:0] fsel;
	logic [5:0] pi_hit;
	logic [5:0] reg_idx;
	logic take;

	// One carrier instance; the top drives selects and periods into it
	gmq_cfg_if cfg ();

	// Select vectors are packed pin by pin, the period vector group by group
	assign fsel = {st.fsel_b1, st.fsel_a2, st.fsel_a1};
	assign cfg.qsel = {st.qsel_b1, st.qsel_a2, st.qsel_a1};
	assign cfg.period = {st.qctl_b, st.qctl_a};
	assign reg_idx = {avs_address[5:2], 2'b00};
	assign take = (avs_read || avs_write) && !st.wait_r;

	// Byte-lane merge for register writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return r;
	endfunction

	// ----------------------------------------
	// Submodules
	// ----------------------------------------
	gmq_tick u_tick (
		.mclk(mclk),
		.rst_n(rst_n),
		.cfg(cfg.tck)
	);

	gmq_qual u_qual (
		.mclk(mclk),
		.rst_n(rst_n),
		.pin_in(pin_in),
		.cfg(cfg.qual)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	// Bus answer takes one stall cycle so read data can come from a flop
	always_comb begin
		logic [31:0] rd;
		logic [31:0] mw;
		logic [1:0] s;
		logic [2:0] id;
		rd = `GMQ_RST32;
		mw = `GMQ_RST32;
		s = 2'h0;
		id = `GMQ_NONE;
		next_st = st;
		pi_hit = 6'h00;
		next_st.wait_r = !((avs_read || avs_write) && st.wait_r);
		// Register writes land on the edge where waitrequest is low
		if (avs_write && take) begin
			case (reg_idx)
				`GMQ_FSEL_A1: next_st.fsel_a1 = merge(st.fsel_a1, avs_writedata, avs_byteenable);
				`GMQ_FSEL_A2: next_st.fsel_a2 = merge(st.fsel_a2, avs_writedata, avs_byteenable);
				`GMQ_FSEL_B1: begin
					// Narrow registers merge as a full word and keep the low bits
					mw = merge({26'h0, st.fsel_b1}, avs_writedata, avs_byteenable);
					next_st.fsel_b1 = mw[5:0];
				end
				`GMQ_QSEL_A1: next_st.qsel_a1 = merge(st.qsel_a1, avs_writedata, avs_byteenable);
				`GMQ_QSEL_A2: next_st.qsel_a2 = merge(st.qsel_a2, avs_writedata, avs_byteenable);
				`GMQ_QSEL_B1: begin
					// Upper lanes fall away; only three pins live here
					mw = merge({26'h0, st.qsel_b1}, avs_writedata, avs_byteenable);
					next_st.qsel_b1 = mw[5:0];
				end
				`GMQ_QCTL_A: next_st.qctl_a = merge(st.qctl_a, avs_writedata, avs_byteenable);
				`GMQ_QCTL_B: begin
					// Only group four has a period byte here
					mw = merge({24'h0, st.qctl_b}, avs_writedata, avs_byteenable);
					next_st.qctl_b = mw[7:0];
				end
				default: ;
			endcase
		end
		// Unmapped reads return zero
		case (reg_idx)
			`GMQ_FSEL_A1: rd = st.fsel_a1;
			`GMQ_FSEL_A2: rd = st.fsel_a2;
			`GMQ_FSEL_B1: rd = {26'h0, st.fsel_b1};
			`GMQ_QSEL_A1: rd = st.qsel_a1;
			`GMQ_QSEL_A2: rd = st.qsel_a2;
			`GMQ_QSEL_B1: rd = {26'h0, st.qsel_b1};
			`GMQ_QCTL_A: rd = st.qctl_a;
			`GMQ_QCTL_B: rd = {24'h0, st.qctl_b};
			`GMQ_LVL_A: rd = st.gdin[31:0];
			`GMQ_LVL_B: rd = {29'h0, st.gdin[34:32]};
			default: rd = `GMQ_RST32;
		endcase
		if (avs_read && st.wait_r) begin
			next_st.rdata = rd;
		end
		// Pad drive per pin
		for (int p = 0; p < `GMQ_NPIN; p++) begin
			s = gmq_field(fsel, p);
			if (s == 2'h0) begin
				next_st.pout[p] = gpio_dout[p];
				next_st.poen[p] = !gpio_dir[p];
			end else begin
				// reserved still drives
				// Reserved codes have no peripheral behind them; the pad follows
				// whatever that lane carries, which is tied off outside
				next_st.pout[p] = alt_dout[3*p + int'(s) - 1];
				next_st.poen[p] = !alt_oe[3*p + int'(s) - 1];
			end
		end
		next_st.gdin = cfg.qval;
		next_st.pin_r = `GMQ_PI_DEFAULT;
		// several candidate pins
		// Walk downward so the lowest-numbered selecting pin wins a conflict
		for (int p = `GMQ_NPIN - 1; p >= 0; p--) begin
			id = gmq_route(p, gmq_field(fsel, p));
			if (id != `GMQ_NONE) begin
				next_st.pin_r[id] = cfg.qval[p];
				pi_hit[id] = 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// All selects reset to zero: plain I/O, sync-only qualification
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.wait_r <= 1'b1;
			st.pout <= '0;
			st.poen <= '1;
			st.pin_r <= `GMQ_PI_DEFAULT;
		end else begin
			st <= next_st;
		end
	end

	// Every output comes straight from a register of the state
	assign avs_readdata = st.rdata;
	assign avs_waitrequest = st.wait_r;
	assign pin_out = st.pout;
	assign pin_oe_n = st.poen;
	assign gpio_din = st.gdin;
	assign periph_in = st.pin_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// All checks run on mclk and pause while reset is held
	default clocking dc @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence

	chk_gpio_drive: assert property (
		gmq_field(fsel, 0) == 2'h0 |=> pin_out[0] == $past(gpio_dout[0])
			&& pin_oe_n[0] == !$past(gpio_dir[0]))
	else $error("pin 0 not driven by GPIO data in I/O mode");

	chk_alt_drive: assert property (
		gmq_field(fsel, 5) == 2'h3 |=> pin_out[5] == $past(alt_dout[17]))
	else $error("pin 5 not driven by its third alternative");

	chk_reserved_drive: assert property (
		gmq_field(fsel, 0) == 2'h2 |=> pin_oe_n[0] == !$past(alt_oe[1]))
	else $error("reserved select changed the pad enable path");

	chk_default_in: assert property (
		!pi_hit[0] |=> periph_in[0] == 1'b1)
	else $error("unselected receive input left its default");

	chk_multi_route: assert property (
		gmq_field(fsel, 13) == 2'h2 && gmq_field(fsel, 10) != 2'h2
		|=> periph_in[0] == $past(cfg.qval[13]))
	else $error("second candidate pin not routed");

	chk_qsel_write: assert property (
		s_req ##1 avs_write && !avs_waitrequest && reg_idx == `GMQ_QSEL_A1
			&& avs_byteenable == 4'hf
		|=> cfg.qsel[31:0] == $past(avs_writedata))
	else $error("qualifier select write did not land");

	chk_bus_answer: assert property (
		s_req |=> !avs_waitrequest)
	else $error("bus answer took more than one stall cycle");

	// The answer lasts one cycle; a held request starts a fresh access
	sequence s_answer;
		(avs_read || avs_write) && !avs_waitrequest;
	endsequence

	// An idle bus keeps the slave stalled, so no stale answer can be seen
	chk_wait_idle: assert property (
		!(avs_read || avs_write) |=> avs_waitrequest)
	else $error("waitrequest fell with no request");

	chk_answer_once: assert property (
		s_answer |=> avs_waitrequest)
	else $error("waitrequest stayed low after the answer");

	// A full-word select write shows up in the routing vector next cycle
	chk_fsel_write: assert property (
		s_req ##1 avs_write && !avs_waitrequest && reg_idx == `GMQ_FSEL_A1
			&& avs_byteenable == 4'hf
		|=> fsel[31:0] == $past(avs_writedata))
	else $error("function select write did not land");

	// Group periods are taken from the written word as they stand
	chk_period_write: assert property (
		s_req ##1 avs_write && !avs_waitrequest && reg_idx == `GMQ_QCTL_A
			&& avs_byteenable == 4'hf
		|=> cfg.period[31:0] == $past(avs_writedata))
	else $error("sample period write did not land");

	// Read data were captured on the stall edge and must match the register
	chk_read_answer: assert property (
		avs_read && !avs_waitrequest && reg_idx == `GMQ_QSEL_A1
		|-> avs_readdata == cfg.qsel[31:0])
	else $error("qualifier select read returned a stale word");

	// Bits above the three upper pins always read as zero
	chk_narrow_read: assert property (
		avs_read && !avs_waitrequest && reg_idx == `GMQ_FSEL_B1
		|-> avs_readdata[31:6] == 26'h0)
	else $error("narrow select read showed upper bits");

	chk_alt_enable: assert property (
		gmq_field(fsel, 5) == 2'h3 |=> pin_oe_n[5] == !$past(alt_oe[17]))
	else $error("pin 5 enable not taken from its third alternative");

	// Level view trails the qualifier by one register stage
	chk_level_view: assert property (
		1'b1 |=> gpio_din == $past(cfg.qval))
	else $error("qualified levels not registered one cycle later");

	// The sync input idles low when no pin feeds it
	chk_sync_default: assert property (
		!pi_hit[4] |=> periph_in[4] == 1'b0)
	else $error("unselected sync input left its low default");

	// Lowest-numbered candidate wins when two pins select one input
	chk_low_pin_wins: assert property (
		gmq_field(fsel, 13) == 2'h2 && gmq_field(fsel, 17) == 2'h2
			&& gmq_field(fsel, 10) != 2'h2
		|=> periph_in[0] == $past(cfg.qval[13]))
	else $error("higher-numbered candidate pin won the route");

endmodule

// [sim/gpio_mux_input_qualifier_bench.sv]
// Self-checking bench for the pin multiplexer and input qualifier.
// Assumes gmq_top on one 250 MHz clock; the bench drives every port itself.
`timescale 1ns/100ps

module gpio_mux_input_qualifier_bench;
	logic mclk;
	logic rst_n;
	logic avs_read;
	logic avs_write;
	logic avs_waitrequest;
	logic snap;
	logic [5:0] avs_address;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic [3:0] avs_byteenable;
	logic [34:0] pin_in, pin_out, pin_oe_n, gpio_dout, gpio_dir, gpio_din, gd, gr;
	logic [104:0] alt_dout, alt_oe, ad, ao;
	logic [5:0] periph_in;
	logic [31:0] r1, r2, eo, en, seen;
	logic [127:0] w;
	logic [31:0] eq[$];
	int kq[$];
	int miscompares;
	int comparisons;
	int cyc;
	int s;
	integer seed = 86545;

	// ----------------------------------------
	// Clock, design and watchdog
	// ----------------------------------------
	always #2 mclk = ~mclk;

	gmq_top i_gmq_top (
		.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .gpio_dout(gpio_dout), .gpio_dir(gpio_dir),
		.gpio_din(gpio_din), .alt_dout(alt_dout), .alt_oe(alt_oe), .periph_in(periph_in)
	);

	// Run takes about 210 cycles; the ceiling leaves wide room
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 4000) begin
			miscompares++;
			tally_and_finish();
		end
	end

	// ----------------------------------------
	// Comparison and closing
	// ----------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] want);
		comparisons++;
		if (got !== want) begin
			miscompares++;
			$display("ERROR %0t: saw %h expected %h", $time, got, want);
		end
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Oldest note is taken at a read answer or at a requested snapshot
	always @(posedge mclk) begin
		if ((avs_read && avs_waitrequest === 1'b0) || snap) begin
			case (kq.size() > 0 ? kq[0] : 0)
				0: seen = avs_readdata;
				1: seen = pin_out[31:0];
				2: seen = pin_oe_n[31:0];
				3: seen = {26'h0, periph_in};
				default: seen = gpio_din[31:0];
			endcase
			if (kq.size() > 0) begin
				void'(kq.pop_front());
				check(seen, eq.pop_front());
			end else begin
				check(seen, 32'hdead_beef);
			end
		end
	end

	// ----------------------------------------
	// Drivers
	// ----------------------------------------
	// One request held until waitrequest is sampled low; idle edge before it
	task automatic bus(input logic wrn, input logic [5:0] a, input logic [31:0] d,
		input logic [3:0] be);
		@(posedge mclk);
		avs_address <= a;
		avs_write <= wrn;
		avs_read <= !wrn;
		avs_writedata <= d;
		avs_byteenable <= be;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
		bus(1'b1, a, d, be);
	endtask

	task automatic rd(input logic [5:0] a, input logic [31:0] e);
		kq.push_back(0);
		eq.push_back(e);
		bus(1'b0, a, 32'h0, 4'hf);
	endtask

	// Snapshot of one output view at the next edge; a gap edge avoids double drive
	task automatic look(input int k, input logic [31:0] e);
		kq.push_back(k);
		eq.push_back(e);
		snap <= 1'b1;
		@(posedge mclk);
		snap <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		rst_n = 1'b0;
		{avs_read, avs_write, snap} = 3'h0;
		avs_address = 6'h00;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h0;
		{pin_in, gpio_dout, gpio_dir} = '0;
		{alt_dout, alt_oe} = '0;
		tick(3);
		rst_n <= 1'b1;
		look(3, 32'h0f);
		for (int a = 0; a < 10; a++) rd(6'(a * 4), 32'h0);
		rd(6'h28, 32'h0);
		wr(6'h2c, 32'hffff_ffff, 4'hf);
		rd(6'h2c, 32'h0);
		$display("test reset_and_unmapped finished");
		// Field storage, narrow register and byte lanes
		r1 = $random(seed);
		wr(6'h00, r1, 4'hf);
		rd(6'h00, r1);
		wr(6'h08, r1, 4'hf);
		rd(6'h08, r1 & 32'h3f);
		wr(6'h04, 32'h1234_5678, 4'hf);
		wr(6'h04, 32'hffff_ffff, 4'h2);
		rd(6'h04, 32'h1234_ff78);
		wr(6'h20, 32'hffff_ffff, 4'hf);
		rd(6'h20, 32'h0);
		$display("test registers finished");
		// Random selects; reserved values are expected to drive their lane
		r2 = $random(seed);
		w = {$random(seed), $random(seed), $random(seed), $random(seed)};
		ad = w[104:0];
		w = {$random(seed), $random(seed), $random(seed), $random(seed)};
		ao = w[104:0];
		gd = w[34:0];
		gr = w[98:64];
		alt_dout <= ad;
		alt_oe <= ao;
		gpio_dout <= gd;
		gpio_dir <= gr;
		wr(6'h04, r2, 4'hf);
		for (int i = 0; i < 32; i++) begin
			s = (i < 16) ? r1[2 * i +: 2] : r2[2 * i - 32 +: 2];
			eo[i] = (s == 0) ? gd[i] : ad[3 * i + s - 1];
			en[i] = (s == 0) ? !gr[i] : !ao[3 * i + s - 1];
		end
		tick(1);
		look(1, eo);
		look(2, en);
		$display("test pin_mux finished");
		// Pins 0..3: window 3, window 6, sync only, no sync; period 3 gives 4 cycles
		wr(6'h00, 32'h0, 4'hf);
		wr(6'h04, 32'h0, 4'hf);
		wr(6'h18, 32'h3, 4'hf);
		wr(6'h0c, 32'hc9, 4'hf);
		rd(6'h18, 32'h3);
		pin_in[3:2] <= 2'b11;
		tick(2);
		look(4, 32'h8);
		tick(4);
		look(4, 32'hc);
		pin_in[0] <= 1'b1;
		tick(2);
		pin_in[0] <= 1'b0;
		tick(30);
		look(4, 32'hc);
		pin_in[1:0] <= 2'b11;
		tick(7);
		look(4, 32'hc);
		tick(12);
		look(4, 32'hd);
		tick(20);
		look(4, 32'hf);
		rd(6'h20, 32'hf);
		$display("test qualifier finished");
		// Pins 6 and 13 feed two inputs, pin 17 competes with 13; reserved pin 30 feeds none
		wr(6'h00, 32'h0800_2000, 4'hf);
		wr(6'h04, 32'h3000_0008, 4'hf);
		pin_in[6] <= 1'b1;
		pin_in[30] <= 1'b1;
		tick(10);
		look(3, 32'h1e);
		pin_in[13] <= 1'b1;
		tick(10);
		look(3, 32'h1f);
		$display("test routing finished");
		tally_and_finish();
	end
endmodule
